// File: shared/dpm_defines.svh
`ifndef DPM_DEFINES_SVH
`define DPM_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DPM_OFS_SHIFT_LO   8'h70
`define DPM_OFS_SHIFT_HI   8'h71
`define DPM_OFS_BO_SKEW    8'h72
`define DPM_OFS_FINE_CFG   8'h73
`define DPM_OFS_COARSE_CFG 8'h74
`define DPM_OFS_MON_CFG    8'h76
`define DPM_OFS_READ_LO    8'h77
`define DPM_OFS_READ_HI    8'h78
`define DPM_OFS_ACQ_TO     8'h79

// ----------------------------------------
// Reset values and writable bit masks
// ----------------------------------------
`define DPM_RST_FINE_CFG   8'ha2
`define DPM_RST_COARSE_CFG 8'h85
`define DPM_RST_MON_CFG    8'h06
`define DPM_RST_ACQ_TO     8'h32
`define DPM_MSK_BO_SKEW    8'h3f
`define DPM_MSK_FINE_CFG   8'he7
`define DPM_MSK_MON_CFG    8'hbf

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DPM_FINE_EN_BIT    7
`define DPM_NALOSS_BIT     6
`define DPM_COARSE_EN_BIT  7
`define DPM_MCPD_EN_BIT    6
`define DPM_MC_LOOP_BIT    5
`define DPM_NW_BIT         7
`define DPM_MON_EN_BIT     5
`define DPM_MON_BO_BIT     4

// ----------------------------------------
// Scaling and timing
// ----------------------------------------
`define DPM_UI_COUNTS      24'd512
`define DPM_FINE_STEP_SH   7
`define DPM_EDGE_TOL       16'd3277
`define DPM_MON_BIAS       14'd7
`define DPM_MON_STEP_QNS   14'd625
`define DPM_CLK_KHZ        250000
`define DPM_ONE_SEC_MS     1000
`define DPM_LOCK_QUAL_S    2

`endif

// File: shared/dpm_pkg.sv
package dpm_pkg;
  typedef enum logic [1:0] {
    DPM_UNLOCKED = 2'b00,
    DPM_QUALIFY  = 2'b01,
    DPM_LOCKED   = 2'b11
  } dpm_lock_e;
  typedef logic signed [23:0] dpm_phase_t;
  typedef logic signed [15:0] dpm_word_t;
  typedef logic [7:0]         dpm_byte_t;
endpackage

// File: verilog/dpm_sec_tick.sv
`timescale 1ns/1ps
`default_nettype none
`include "dpm_defines.svh"
module dpm_sec_tick #(
  parameter int unsigned SEC_CYCLES = `DPM_ONE_SEC_MS * `DPM_CLK_KHZ
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  output logic      tick
);
  logic [31:0] cnt_q;
  logic        tick_q;
  wire         wrap = (cnt_q == 32'(SEC_CYCLES - 1));

  // Elaboration stops on a second too short for the wrap compare
  if (SEC_CYCLES < 2) begin : g_bad_cycles
    $error("SEC_CYCLES must be at least 2");
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= 32'h0;
      tick_q <= 1'b0;
    end else if (ce) begin
      cnt_q  <= wrap ? 32'h0 : cnt_q + 32'h1;
      tick_q <= wrap;
    end
  end

  assign tick = tick_q;
endmodule
`default_nettype wire

// File: verilog/dpm_lock_monitor.sv
// Notes on behaviour
// R1 - Shift word bits 15:8 at 0x71
// R2 - Build-out event applies signed skew field
// R3 - Software keeps skew within 1.4 ns
// R4 - Fine window gated by enable, both loops
// R5 - Inactivity without flag: no loss, nearest-edge
// R6 - Inactivity with flag: loss, full-cycle range
// R7 - Software keeps fine config bit 5 set
// R8 - Lock after two seconds inside; loss immediately
// R9 - Fine select: 0 never locks, wider codes
// R10 - Coarse window gated by enable, both loops
// R11 - Multicycle detector tracks coarse range
// R12 - Loop phase clamped to 360 or coarse
// R13 - Software enables detector with in-loop bit
// R14 - Coarse code gives 2^(n+1)-1 UI, max 8191
// R15 - Software disables fine window for multi-UI
// R16 - Low-rate edges outside 5% ignored
// R17 - Monitor alarm when error exceeds threshold
// R18 - Threshold is (field+7) times 156.25 ns
// R19 - Alarm starts build-out only when enabled
// R20 - Averaged readout from selected loop
// R21 - Software reads readout bytes back to back
// R22 - Main acquisition timeout raises lock alarm
// R23 - Shift word ramps, ignored during build-out/unlock
// R24 - Software accesses shift bytes back to back
// R25 - Low readout read captures high byte
`timescale 1ns/1ps
`default_nettype none
`include "dpm_defines.svh"
module dpm_lock_monitor #(
  parameter int unsigned SEC_CYCLES = `DPM_ONE_SEC_MS * `DPM_CLK_KHZ
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic [7:0]       reg_addr,
  input  wire dpm_pkg::dpm_byte_t reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output dpm_pkg::dpm_byte_t    reg_rdata,
  input  wire logic             readout_loop_select,
  input  wire logic             buildout_enable,
  input  wire dpm_pkg::dpm_phase_t main_phase,
  input  wire dpm_pkg::dpm_phase_t aux_phase,
  input  wire logic             main_active,
  input  wire logic             aux_active,
  input  wire logic             main_low_rate,
  input  wire logic             aux_low_rate,
  input  wire logic             main_edge_valid,
  input  wire logic             aux_edge_valid,
  input  wire dpm_pkg::dpm_word_t main_edge_pos,
  input  wire dpm_pkg::dpm_word_t aux_edge_pos,
  input  wire dpm_pkg::dpm_word_t main_avg,
  input  wire dpm_pkg::dpm_word_t aux_avg,
  input  wire logic [15:0]      mon_err_qns,
  input  wire logic             main_acquiring,
  input  wire logic             lock_alarm_clr,
  output logic                  main_locked,
  output logic                  aux_locked,
  output dpm_pkg::dpm_phase_t   main_loop_phase,
  output dpm_pkg::dpm_phase_t   aux_loop_phase,
  output logic                  main_edge_accept,
  output logic                  aux_edge_accept,
  output logic                  monitor_alarm,
  output logic                  buildout_event,
  output logic [5:0]            buildout_skew_out,
  output dpm_pkg::dpm_word_t    phase_shift_out,
  output logic                  lock_alarm
);
  import dpm_pkg::*;

  // Elaboration stops on a second too short for the tick counter
  if (SEC_CYCLES < 2) begin : g_bad_cycles
    $error("SEC_CYCLES must be at least 2");
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  dpm_byte_t shift_lo_q, shift_hi_q, skew_q, fine_q, coarse_q, mon_q, acq_q;
  dpm_byte_t rdata_q, hold_hi_q;
  dpm_word_t shift_tgt_q, shift_out_q;

  wire wr_lo     = reg_wr && (reg_addr == `DPM_OFS_SHIFT_LO);
  wire wr_hi     = reg_wr && (reg_addr == `DPM_OFS_SHIFT_HI);
  wire wr_skew   = reg_wr && (reg_addr == `DPM_OFS_BO_SKEW);
  wire wr_fine   = reg_wr && (reg_addr == `DPM_OFS_FINE_CFG);
  wire wr_coarse = reg_wr && (reg_addr == `DPM_OFS_COARSE_CFG);
  wire wr_mon    = reg_wr && (reg_addr == `DPM_OFS_MON_CFG);
  wire wr_acq    = reg_wr && (reg_addr == `DPM_OFS_ACQ_TO);
  wire rd_lo_avg = reg_rd && (reg_addr == `DPM_OFS_READ_LO);

  wire       fine_en     = fine_q[`DPM_FINE_EN_BIT];
  wire       na_loss     = fine_q[`DPM_NALOSS_BIT];
  wire [2:0] fine_sel    = fine_q[2:0];
  wire       coarse_en   = coarse_q[`DPM_COARSE_EN_BIT];
  wire       mcpd_en     = coarse_q[`DPM_MCPD_EN_BIT];
  wire       mc_in_loop  = coarse_q[`DPM_MC_LOOP_BIT];
  wire [3:0] coarse_sel  = coarse_q[3:0];
  wire       noise_win   = mon_q[`DPM_NW_BIT];
  wire       mon_en      = mon_q[`DPM_MON_EN_BIT];
  wire       mon_bo      = mon_q[`DPM_MON_BO_BIT];
  wire [3:0] mon_thr_sel = mon_q[3:0];
  wire [5:0] acq_cnt     = acq_q[5:0];
  wire [1:0] acq_scale   = acq_q[7:6];

  // Readout source, R20; high byte of the same sample is held, R25
  wire dpm_word_t sel_avg = readout_loop_select ? aux_avg : main_avg; // [R20]

  wire dpm_byte_t rd_mux =
    (reg_addr == `DPM_OFS_SHIFT_LO)   ? shift_lo_q :
    (reg_addr == `DPM_OFS_SHIFT_HI)   ? shift_hi_q :
    (reg_addr == `DPM_OFS_BO_SKEW)    ? skew_q :
    (reg_addr == `DPM_OFS_FINE_CFG)   ? fine_q :
    (reg_addr == `DPM_OFS_COARSE_CFG) ? coarse_q :
    (reg_addr == `DPM_OFS_MON_CFG)    ? mon_q :
    (reg_addr == `DPM_OFS_READ_LO)    ? sel_avg[7:0] :
    (reg_addr == `DPM_OFS_READ_HI)    ? hold_hi_q :
    (reg_addr == `DPM_OFS_ACQ_TO)     ? acq_q : 8'h00;

  // Fine config bit 5 stored as written; software keeps it set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_lo_q  <= 8'h00;
      shift_hi_q  <= 8'h00;
      shift_tgt_q <= 16'sh0;
      skew_q      <= 8'h00;
      fine_q      <= `DPM_RST_FINE_CFG;
      coarse_q    <= `DPM_RST_COARSE_CFG;
      mon_q       <= `DPM_RST_MON_CFG;
      acq_q       <= `DPM_RST_ACQ_TO;
    end else if (ce) begin
      if (wr_lo) shift_lo_q <= reg_wdata;
      if (wr_hi) begin
        shift_hi_q  <= reg_wdata;                  // [R1]
        shift_tgt_q <= {reg_wdata, shift_lo_q};    // [R1] [R24]
      end
      if (wr_skew)   skew_q   <= reg_wdata & `DPM_MSK_BO_SKEW;
      if (wr_fine)   fine_q   <= reg_wdata & `DPM_MSK_FINE_CFG; // [R7]
      if (wr_coarse) coarse_q <= reg_wdata;
      if (wr_mon)    mon_q    <= reg_wdata & `DPM_MSK_MON_CFG;
      if (wr_acq)    acq_q    <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q   <= 8'h00;
      hold_hi_q <= 8'h00;
    end else if (ce) begin
      if (reg_rd)    rdata_q   <= rd_mux;
      if (rd_lo_avg) hold_hi_q <= sel_avg[15:8]; // [R25] [R21]
    end
  end

  assign reg_rdata = rdata_q;

  // ----------------------------------------
  // Window limits
  // ----------------------------------------
  function automatic logic [22:0] coarse_ui_lim(input logic [3:0] c);
    logic [4:0] e;
    e = (c > 4'hb) ? 5'd13 : 5'({1'b0, c}) + 5'd1; // [R14]
    coarse_ui_lim = 23'(((23'd1 << e) - 23'd1) << 9);
  endfunction

  wire [22:0] coarse_lim = coarse_ui_lim(coarse_sel);                   // [R14]
  wire [23:0] fine_lim   = 24'({fine_sel, 7'h00});                      // [R9]
  wire [23:0] clamp_lim  = mc_in_loop ? {1'b0, coarse_lim} : `DPM_UI_COUNTS; // [R12]

  wire       tick;
  dpm_lock_e lk_q [2];
  logic [1:0] qual_q [2];
  dpm_phase_t loop_q [2];
  logic [1:0] edge_acc_q;

  dpm_sec_tick #(
    .SEC_CYCLES (SEC_CYCLES)
  ) u_tick (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .tick  (tick)
  );

  wire dpm_phase_t raw   [2] = '{main_phase, aux_phase};
  wire dpm_word_t  epos  [2] = '{main_edge_pos, aux_edge_pos};
  wire [1:0] act   = {aux_active, main_active};
  wire [1:0] lowr  = {aux_low_rate, main_low_rate};
  wire [1:0] evld  = {aux_edge_valid, main_edge_valid};

  // ----------------------------------------
  // Per-loop phase detector and lock state
  // ----------------------------------------
  // One configuration serves both loops; the inputs, lock state and loop phase are per loop
  for (genvar l = 0; l < 2; l++) begin : g_loop
    // Without the multicycle detector phase folds into one cycle
    wire dpm_phase_t w180 = {{15{raw[l][8]}}, raw[l][8:0]};       // [R5]
    wire dpm_phase_t w360 = {{14{raw[l][9]}}, raw[l][9:0]};       // [R6]
    wire dpm_phase_t wrp  = mcpd_en ? raw[l] : (na_loss ? w360 : w180); // [R11]
    wire [23:0] mag  = wrp[23] ? 24'(-wrp) : 24'(wrp);
    wire in_fine   = !fine_en || (fine_sel != 3'b000 && mag <= fine_lim); // [R4] [R9]
    wire in_coarse = !coarse_en || mag <= {1'b0, coarse_lim};          // [R10]
    // Missing cycles are ignored unless flagged as loss
    wire lose = act[l] ? !(in_fine && in_coarse) : na_loss;          // [R5] [R6]
    wire hold = !act[l] && !na_loss;                                  // [R5]
    wire dpm_phase_t hi_c = dpm_phase_t'(clamp_lim);
    wire dpm_phase_t clp  = ($signed(wrp) > hi_c) ? hi_c :
                            ($signed(wrp) < -hi_c) ? -hi_c : wrp;     // [R12]
    wire [15:0] emag = epos[l][15] ? 16'(-epos[l]) : 16'(epos[l]);
    wire e_ok = !noise_win || !lowr[l] || emag <= `DPM_EDGE_TOL;      // [R16]

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        lk_q[l]   <= DPM_UNLOCKED;
        qual_q[l] <= 2'd0;
      end else if (ce && !hold) begin
        unique case (lk_q[l])
          DPM_UNLOCKED: begin
            qual_q[l] <= 2'd0;
            if (!lose) lk_q[l] <= DPM_QUALIFY;
          end
          DPM_QUALIFY: begin
            if (lose) begin
              lk_q[l] <= DPM_UNLOCKED;                                 // [R8]
            end else if (tick) begin
              qual_q[l] <= qual_q[l] + 2'd1;
              if (qual_q[l] == 2'(`DPM_LOCK_QUAL_S - 1)) lk_q[l] <= DPM_LOCKED; // [R8]
            end
          end
          DPM_LOCKED: begin
            if (lose) lk_q[l] <= DPM_UNLOCKED;                         // [R8]
          end
          default: lk_q[l] <= DPM_UNLOCKED;
        endcase
      end
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        loop_q[l]     <= '0;
        edge_acc_q[l] <= 1'b0;
      end else if (ce) begin
        loop_q[l]     <= clp;                                          // [R12]
        edge_acc_q[l] <= evld[l] && e_ok;                              // [R16]
      end
    end
  end

  assign main_locked      = (lk_q[0] == DPM_LOCKED);
  assign aux_locked       = (lk_q[1] == DPM_LOCKED);
  assign main_loop_phase  = loop_q[0];
  assign aux_loop_phase   = loop_q[1];
  assign main_edge_accept = edge_acc_q[0];
  assign aux_edge_accept  = edge_acc_q[1];

  // ----------------------------------------
  // Phase monitor and build-out
  // ----------------------------------------
  wire [13:0] mon_thr = 14'((14'(mon_thr_sel) + `DPM_MON_BIAS) * `DPM_MON_STEP_QNS); // [R18]
  wire        mon_hit = mon_en && (mon_err_qns > 16'(mon_thr));             // [R17]
  logic       alarm_q, bo_evt_q;
  logic [5:0] bo_skew_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_q   <= 1'b0;
      bo_evt_q  <= 1'b0;
      bo_skew_q <= 6'h00;
    end else if (ce) begin
      alarm_q  <= mon_hit;                               // [R17]
      bo_evt_q <= mon_hit && !alarm_q && mon_bo;         // [R19]
      if (mon_hit && !alarm_q && mon_bo) bo_skew_q <= skew_q[5:0]; // [R2]
    end
  end

  assign monitor_alarm     = alarm_q;
  assign buildout_event    = bo_evt_q;
  assign buildout_skew_out = bo_skew_q;

  // ----------------------------------------
  // Output phase shift ramp
  // ----------------------------------------
  // One count per cycle keeps the output step small enough to hold sync
  wire ramp_ok = !buildout_enable && !mon_bo && main_locked;              // [R23]

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_out_q <= 16'sh0;
    end else if (ce && ramp_ok) begin
      if (shift_out_q < shift_tgt_q)      shift_out_q <= shift_out_q + 16'sh1; // [R23]
      else if (shift_out_q > shift_tgt_q) shift_out_q <= shift_out_q - 16'sh1; // [R23]
    end
  end

  assign phase_shift_out = shift_out_q;

  // ----------------------------------------
  // Acquisition timeout
  // ----------------------------------------
  logic [9:0] acq_sec_q;
  logic       lk_alarm_q;
  // Shift amount is three bits wide; a two-bit sum would wrap at the top scale
  wire  [9:0] acq_lim = 10'({4'h0, acq_cnt} << (3'(acq_scale) + 3'd1)); // [R22]
  wire        acq_over = main_acquiring && (acq_sec_q > acq_lim);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acq_sec_q  <= 10'h000;
      lk_alarm_q <= 1'b0;
    end else if (ce) begin
      if (!main_acquiring)             acq_sec_q <= 10'h000;
      else if (tick && ~&acq_sec_q)    acq_sec_q <= acq_sec_q + 10'h001;
      // A timeout in the clearing cycle still lands
      lk_alarm_q <= acq_over || (lk_alarm_q && !lock_alarm_clr);     // [R22]
    end
  end

  assign lock_alarm = lk_alarm_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_shift_high_store: assert property ( // [R1]
    ce && wr_hi |=> shift_tgt_q == {$past(reg_wdata), shift_lo_q})
    else $error("shift high write not committed");
  chk_skew_on_event: assert property ( // [R2]
    $rose(bo_evt_q) |-> bo_skew_q == $past(skew_q[5:0]))
    else $error("build-out skew not applied");
  chk_fine_off_holds: assert property ( // [R4]
    ce && !fine_en && main_active && g_loop[0].in_coarse && lk_q[0] == DPM_LOCKED
    |=> lk_q[0] == DPM_LOCKED)
    else $error("lock lost with windows disabled");
  chk_inactive_holds: assert property ( // [R5]
    ce && !na_loss && !main_active && lk_q[0] == DPM_LOCKED |=> main_locked)
    else $error("lock lost on inactivity without flag");
  chk_inactive_loses: assert property ( // [R6]
    ce && na_loss && !main_active |=> lk_q[0] == DPM_UNLOCKED)
    else $error("inactivity did not drop lock");
  chk_lock_after_qual: assert property ( // [R8]
    $rose(main_locked) |-> $past(tick) && $past(qual_q[0]) == 2'd1)
    else $error("lock declared early");
  chk_fine_zero_unlock: assert property ( // [R9]
    ce && fine_en && fine_sel == 3'b000 && main_active |=> !main_locked)
    else $error("fine code zero allowed lock");
  chk_clamp_cycle: assert property ( // [R12]
    ce && !mc_in_loop |=> main_loop_phase <= 24'sd512 && main_loop_phase >= -24'sd512)
    else $error("loop phase not clamped");
  chk_monitor_alarm: assert property ( // [R17]
    ce && mon_en && mon_err_qns > 16'(mon_thr) |=> monitor_alarm)
    else $error("monitor alarm missed");
  chk_bo_gated: assert property ( // [R19]
    buildout_event |-> $past(mon_bo) && monitor_alarm)
    else $error("build-out without enable");
  chk_readout_hold: assert property ( // [R25]
    ce && rd_lo_avg |=> hold_hi_q == $past(sel_avg[15:8]))
    else $error("readout high byte not captured");
  chk_timeout_alarm: assert property ( // [R22]
    ce && acq_over |=> lock_alarm)
    else $error("acquisition timeout missed");

  cov_lock_reached: cover property (main_locked ##1 aux_locked);
  cov_buildout:     cover property (buildout_event);
  cov_timeout:      cover property ($rose(lock_alarm));
endmodule
`default_nettype wire

// File: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dpm_defines.svh"
module tb_top;
  import dpm_pkg::*;
  // ----------------------------------------
  // Stimulus and design
  // ----------------------------------------
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  dpm_byte_t   reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  dpm_byte_t   reg_rdata;
  logic        sel = 1'b0;
  logic        bo_en = 1'b0;
  dpm_phase_t  phase = 24'h000000;
  logic        active = 1'b1;
  logic        low_rate = 1'b0;
  logic        edge_v = 1'b0;
  dpm_word_t   edge_pos = 16'h0000;
  dpm_word_t   main_avg = 16'h0000;
  dpm_word_t   aux_avg = 16'h0000;
  logic [15:0] mon_err = 16'h0000;
  logic        acq = 1'b0;
  logic        la_clr = 1'b0;
  logic        ce = 1'b1;
  dpm_phase_t  loop_m, loop_a;
  logic        main_locked, aux_locked, main_acc, aux_acc, mon_alarm, bo_event, lock_alarm;
  logic [5:0]  skew_out;
  dpm_word_t   shift_out;
  int          err_total = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          i;
  // Short second keeps the two-second qualify and the timeouts cheap
  dpm_lock_monitor #(.SEC_CYCLES(20)) dpm_lock_monitor_i (
    .clk(clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .readout_loop_select(sel),
    .buildout_enable(bo_en), .main_phase(phase), .aux_phase(phase), .main_active(active),
    .aux_active(active), .main_low_rate(low_rate), .aux_low_rate(low_rate),
    .main_edge_valid(edge_v), .aux_edge_valid(edge_v), .main_edge_pos(edge_pos),
    .aux_edge_pos(edge_pos), .main_avg(main_avg), .aux_avg(aux_avg), .mon_err_qns(mon_err),
    .main_acquiring(acq), .lock_alarm_clr(la_clr), .main_locked(main_locked),
    .aux_locked(aux_locked), .main_loop_phase(loop_m), .aux_loop_phase(loop_a),
    .main_edge_accept(main_acc), .aux_edge_accept(aux_acc), .monitor_alarm(mon_alarm),
    .buildout_event(bo_event), .buildout_skew_out(skew_out), .phase_shift_out(shift_out),
    .lock_alarm(lock_alarm));
  always #2 clk = ~clk;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Hung waits must still reach the verdict, so count a mismatch and close
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_total++;
      tally_and_finish();
    end
  end
  task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    chk_val({23'h0, got}, {23'h0, exp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    chk_val({16'h0, reg_rdata}, {16'h0, exp});
  endtask
  task automatic edge_chk(input logic [15:0] pos, input logic exp);
    @(negedge clk);
    edge_pos = pos;
    edge_v = 1'b1;
    @(negedge clk);
    edge_v = 1'b0;
    chk_flag(main_acc, exp);
    chk_flag(aux_acc, exp);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wait_lock();
    for (i = 0; i < 100 && main_locked !== 1'b1; i++) @(negedge clk);
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  logic [7:0] ra [10] = '{8'h70, 8'h71, 8'h72, 8'h73, 8'h74, 8'h76, 8'h77, 8'h78, 8'h79, 8'h75};
  logic [7:0] rv [10] = '{8'h00, 8'h00, 8'h00, 8'ha2, 8'h85, 8'h06, 8'h00, 8'h00, 8'h32, 8'h00};
  initial begin
    wait_cyc(10);
    rst_n = 1'b1;
    foreach (ra[k]) rd(ra[k], rv[k]);
    wr(`DPM_OFS_BO_SKEW, 8'hff);
    rd(`DPM_OFS_BO_SKEW, 8'h3f);
    wr(`DPM_OFS_FINE_CFG, 8'hff);
    rd(`DPM_OFS_FINE_CFG, 8'he7);
    wr(`DPM_OFS_MON_CFG, 8'hff);
    rd(`DPM_OFS_MON_CFG, 8'hbf);
    wr(8'h75, 8'h5a);
    rd(8'h75, 8'h00);
    $display("test registers done");
    main_avg = 16'h1234;
    aux_avg = 16'hbeef;
    wr(`DPM_OFS_READ_LO, 8'h55);
    rd(`DPM_OFS_READ_LO, 8'h34);
    main_avg = 16'h5678;
    rd(`DPM_OFS_READ_HI, 8'h12);
    sel = 1'b1;
    rd(`DPM_OFS_READ_LO, 8'hef);
    rd(`DPM_OFS_READ_HI, 8'hbe);
    $display("test readout done");
    low_rate = 1'b1;
    wr(`DPM_OFS_MON_CFG, 8'h00);
    edge_chk(16'd4000, 1'b1);
    wr(`DPM_OFS_MON_CFG, 8'h80);
    edge_chk(16'd4000, 1'b0);
    edge_chk(16'd3000, 1'b1);
    edge_chk(16'hf448, 1'b1);
    edge_chk(16'hf060, 1'b0);
    $display("test noise window done");
    // Skew of -13 counts stays inside the safe build-out range
    wr(`DPM_OFS_BO_SKEW, 8'h33);
    wr(`DPM_OFS_MON_CFG, 8'h30);
    mon_err = 16'd4375;
    wait_cyc(3);
    chk_flag(mon_alarm, 1'b0);
    mon_err = 16'd4376;
    wait_cyc(1);
    chk_flag(mon_alarm, 1'b1);
    chk_flag(bo_event, 1'b1);
    chk_val({18'h0, skew_out}, 24'h000033);
    wait_cyc(1);
    chk_flag(bo_event, 1'b0);
    mon_err = 16'h0000;
    wr(`DPM_OFS_MON_CFG, 8'h2f);
    mon_err = 16'd13750;
    wait_cyc(3);
    chk_flag(mon_alarm, 1'b0);
    mon_err = 16'd13751;
    wait_cyc(1);
    chk_flag(mon_alarm, 1'b1);
    chk_flag(bo_event, 1'b0);
    mon_err = 16'h0000;
    wr(`DPM_OFS_MON_CFG, 8'h00);
    $display("test monitor done");
    // Bit 5 of the fine config stays set throughout
    wr(`DPM_OFS_FINE_CFG, 8'ha0);
    wr(`DPM_OFS_SHIFT_LO, 8'h03);
    wr(`DPM_OFS_SHIFT_HI, 8'h00);
    wait_cyc(100);
    chk_flag(main_locked, 1'b0);
    chk_val({8'h0, shift_out}, 24'h0);
    wr(`DPM_OFS_FINE_CFG, 8'ha1);
    wait_cyc(15);
    chk_flag(main_locked, 1'b0);
    wait_lock();
    chk_flag(main_locked, 1'b1);
    chk_flag(aux_locked, 1'b1);
    active = 1'b0;
    wait_cyc(3);
    chk_flag(main_locked, 1'b1);
    wr(`DPM_OFS_FINE_CFG, 8'he1);
    wait_cyc(2);
    chk_flag(main_locked, 1'b0);
    active = 1'b1;
    wr(`DPM_OFS_FINE_CFG, 8'ha1);
    wait_lock();
    chk_flag(main_locked, 1'b1);
    phase = 24'd200;
    wait_cyc(2);
    chk_flag(main_locked, 1'b0);
    chk_flag(aux_locked, 1'b0);
    wr(`DPM_OFS_FINE_CFG, 8'h21);
    wait_lock();
    chk_flag(main_locked, 1'b1);
    $display("test lock done");
    wr(`DPM_OFS_SHIFT_LO, 8'h05);
    wr(`DPM_OFS_SHIFT_HI, 8'h00);
    wait_cyc(12);
    chk_val({8'h0, shift_out}, 24'h000005);
    bo_en = 1'b1;
    wr(`DPM_OFS_SHIFT_LO, 8'h0a);
    wr(`DPM_OFS_SHIFT_HI, 8'h00);
    wait_cyc(12);
    chk_val({8'h0, shift_out}, 24'h000005);
    bo_en = 1'b0;
    wr(`DPM_OFS_SHIFT_LO, 8'h00);
    wr(`DPM_OFS_SHIFT_HI, 8'h01);
    rd(`DPM_OFS_SHIFT_HI, 8'h01);
    wait_cyc(300);
    chk_val({8'h0, shift_out}, 24'h000100);
    $display("test phase shift done");
    // Clock enable low must swallow a write
    ce = 1'b0;
    wr(`DPM_OFS_FINE_CFG, 8'h20);
    ce = 1'b1;
    rd(`DPM_OFS_FINE_CFG, 8'h21);
    phase = 24'd600;
    wait_cyc(2);
    chk_val(loop_m, 24'h000058);
    wr(`DPM_OFS_FINE_CFG, 8'h61);
    wait_cyc(2);
    chk_val(loop_m, 24'hfffe58);
    wr(`DPM_OFS_COARSE_CFG, 8'he5);
    wait_cyc(2);
    chk_val(loop_a, 24'h000258);
    chk_flag(main_locked, 1'b1);
    phase = 24'd40000;
    wait_cyc(2);
    chk_val(loop_m, 24'h007e00);
    chk_flag(main_locked, 1'b0);
    wr(`DPM_OFS_COARSE_CFG, 8'hc5);
    wait_cyc(2);
    chk_val(loop_m, 24'h000200);
    $display("test loop phase done");
    wr(`DPM_OFS_ACQ_TO, 8'h01);
    acq = 1'b1;
    wait_cyc(30);
    chk_flag(lock_alarm, 1'b0);
    for (i = 0; i < 60 && lock_alarm !== 1'b1; i++) @(negedge clk);
    chk_flag(lock_alarm, 1'b1);
    acq = 1'b0;
    la_clr = 1'b1;
    wait_cyc(1);
    la_clr = 1'b0;
    wait_cyc(1);
    chk_flag(lock_alarm, 1'b0);
    $display("test timeout done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
